// File: wake_timer_consts.vh
/*
 * Constants of the wake timer unit: register indices, field positions,
 * reset values and timing figures.
 * Assumes inclusion by plain Verilog-2005 files; the byte address of a
 * register is four times its index.
 */
`ifndef WAKE_TIMER_CONSTS_VH
`define WAKE_TIMER_CONSTS_VH

// register indices
`define IDX_INTERRUPT_MASK_LOW    10'h100
`define IDX_WAKE_EVENT_COUNTER    10'h103
`define IDX_WAKE_THRESHOLD_A      10'h104
`define IDX_WAKE_THRESHOLD_B      10'h105
`define IDX_WAKE_COMMAND          10'h30B
`define IDX_WAKE_CONFIG_UPPER     10'h30C
`define IDX_WAKE_CONFIG_LOWER     10'h30D
`define IDX_WAKE_PERIOD           10'h30E
`define IDX_WAKE_FLAG_CLEAR       10'h30F
`define IDX_WAKE_STATUS           10'h311
`define IDX_RC_CAL_RESULT_UPPER   10'h34F
`define IDX_RC_CAL_RESULT_LOWER   10'h350

// wake_config_lower fields
`define CFG_TIMEOUT_WAKE_ARM      0
`define CFG_RETENTION_RAM_POWER   3
`define CFG_SLEEP_CLOCK_SELECT    4
`define CFG_CRYSTAL_OSC_ENABLE    5
`define CFG_RC_OSC_ENABLE         6

// other fields
`define MASK_WAKE_COUNT_IRQ       0
`define FLAG_IRQ_CLEAR            0
`define FLAG_RC_CAL_TRIGGER       1
`define CMD_ENTER_SLEEP           0
`define CMD_LEAVE_OFF             1

// reset values
`define RST_WAKE_CONFIG_LOWER     8'h00
`define RST_WAKE_CONFIG_UPPER     8'h28
`define RST_INTERRUPT_MASK        8'h00
`define RST_WAKE_THRESHOLD        16'h0000
`define RST_WAKE_PERIOD           16'h0020

// timing
`define MCLK_PERIOD_NS            5
`define RC_FINE_CAL_TIME_NS       1500000

// bus answers
`define RESP_OKAY                 2'b00
`define RESP_SLVERR               2'b10

`endif

// File: rc_fine_cal.v
/*
 * Fine calibration engine of the internal RC sleep oscillator: counts
 * RC ticks inside a fixed window of mclk cycles.
 * Assumes rc_tick is a one-cycle pulse already synchronised to mclk.
 */
`timescale 1ns/1ps
`include "wake_timer_consts.vh"

module rc_fine_cal #(
   parameter CAL_CYCLES = `RC_FINE_CAL_TIME_NS / `MCLK_PERIOD_NS,
   parameter RES_WIDTH  = 16
) (
   // clock and reset
   input  wire                 mclk,
   input  wire                 rstn,
   // control
   input  wire                 start,
   input  wire                 rc_tick,
   // status and result
   output reg                  busy,
   output reg                  done,
   output reg [RES_WIDTH-1:0]  result
);

   reg [31:0]          window_reg;
   reg [RES_WIDTH-1:0] tick_cnt_reg;

   always @(posedge mclk) begin
      if (!rstn) begin
         busy         <= 1'b0;
         done         <= 1'b0;
         result       <= {RES_WIDTH{1'b0}};
         window_reg   <= 32'h00000000;
         tick_cnt_reg <= {RES_WIDTH{1'b0}};
      end else if (start) begin
         // a new start restarts the window, even mid-run
         busy         <= 1'b1;
         done         <= 1'b0;
         window_reg   <= 32'h00000000;
         tick_cnt_reg <= {RES_WIDTH{1'b0}};
      end else if (busy) begin
         if (rc_tick)
            tick_cnt_reg <= tick_cnt_reg + {{(RES_WIDTH-1){1'b0}}, 1'b1};
         if (window_reg == CAL_CYCLES - 1) begin
            busy   <= 1'b0;
            done   <= 1'b1;
            result <= rc_tick ? tick_cnt_reg + {{(RES_WIDTH-1){1'b0}}, 1'b1} : tick_cnt_reg;
         end else begin
            window_reg <= window_reg + 32'h00000001;
         end
      end
   end

endmodule // rc_fine_cal

// File: wake_timer_unit.v
/*
 * Wake timer unit: sleep clock source control, retention RAM power,
 * timed wake-ups counted against a 16-bit threshold with interrupt,
 * and RC oscillator fine calibration, behind an AXI4-Lite slave.
 * Assumes the two sleep oscillators arrive as asynchronous pins and
 * that mclk runs throughout.
 */
// Our own choice: the AXI4-Lite interface to the registers.
// Operation
// - config lower bit 4 picks RC oscillator when 1, crystal when 0
// - config lower bit 3 keeps retention RAM powered during sleep
// - config lower bit 0 arms wake-up on timer timeout
// - config lower bit 6 enables the RC oscillator
// - config lower bit 5 enables the crystal oscillator
// - while armed, sleep ends at the programmed interval
// - every wake-up increments the wake counter at 0x103
// - counter above threshold is cleared to zero
// - on that clear with mask bit set, raise line 3 and go off
// - fine calibration starts on every wake and on cold start
// - bus reads, writes and commands stay served during calibration
// - calibration progress and status readable at 0x311
// - calibration result readable at 0x34F high and 0x350 low
// - fine calibration completes within about 1.5 ms
`timescale 1ns/1ps
`include "wake_timer_consts.vh"

module wake_timer_unit #(
   parameter CAL_CYCLES = `RC_FINE_CAL_TIME_NS / `MCLK_PERIOD_NS
) (
   // clock and reset
   input  wire        mclk,
   input  wire        rstn,
   // axi4-lite write address
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // sleep oscillator pins
   input  wire        rc_osc_clk,
   input  wire        crystal_osc_clk,
   // power and oscillator controls
   output reg         rc_osc_enable,
   output reg         crystal_osc_enable,
   output reg         sleep_clock_select,
   output reg         retention_ram_power,
   output reg         sleep_state,
   output reg         off_state,
   // host interrupt
   output reg         general_interrupt_line_3
);

   localparam ST_ACTIVE = 3'b001;
   localparam ST_SLEEP  = 3'b010;
   localparam ST_OFF    = 3'b100;

   function mapped;
      input [9:0] idx;
      begin
         case (idx)
            `IDX_INTERRUPT_MASK_LOW, `IDX_WAKE_EVENT_COUNTER, `IDX_WAKE_THRESHOLD_A,
            `IDX_WAKE_THRESHOLD_B, `IDX_WAKE_COMMAND, `IDX_WAKE_CONFIG_UPPER,
            `IDX_WAKE_CONFIG_LOWER, `IDX_WAKE_PERIOD, `IDX_WAKE_FLAG_CLEAR,
            `IDX_WAKE_STATUS, `IDX_RC_CAL_RESULT_UPPER, `IDX_RC_CAL_RESULT_LOWER:
               mapped = 1'b1;
            default:
               mapped = 1'b0;
         endcase
      end
   endfunction

   // sleep oscillator synchronisers, index 0 rc, index 1 crystal
   wire [1:0] osc_pin = {crystal_osc_clk, rc_osc_clk};
   reg  [1:0] sync1_reg;
   reg  [1:0] sync2_reg;
   reg  [1:0] sync3_reg;
   reg  [1:0] osc_level_reg;
   reg  [1:0] osc_tick_reg;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_osc
         always @(posedge mclk) begin
            if (!rstn) begin
               sync1_reg[g]     <= 1'b0;
               sync2_reg[g]     <= 1'b0;
               sync3_reg[g]     <= 1'b0;
               osc_level_reg[g] <= 1'b0;
               osc_tick_reg[g]  <= 1'b0;
            end else begin
               sync1_reg[g] <= osc_pin[g];
               sync2_reg[g] <= sync1_reg[g];
               sync3_reg[g] <= sync2_reg[g];
               // a level counts only once stages two and three agree
               if (sync2_reg[g] == sync3_reg[g])
                  osc_level_reg[g] <= sync3_reg[g];
               osc_tick_reg[g] <= (sync2_reg[g] == sync3_reg[g]) & sync3_reg[g] & ~osc_level_reg[g];
            end
         end
      end
   endgenerate

   // registers
   reg [7:0]  cfg_lower_reg;
   reg [7:0]  cfg_upper_reg;
   reg [7:0]  irq_mask_reg;
   reg [15:0] threshold_reg;
   reg [15:0] period_reg;
   reg [15:0] wake_count_reg;
   reg        cal_trigger_reg;
   reg        cold_start_reg;
   reg [2:0]  state_reg;
   reg [15:0] period_cnt_reg;

   // bus write side
   reg [9:0]  aw_idx_reg;
   reg        aw_held_reg;
   reg [31:0] w_data_reg;
   reg [3:0]  w_strb_reg;
   reg        w_held_reg;

   wire       wr_fire  = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   wire       wr_lane0 = wr_fire & w_strb_reg[0];
   wire       wr_lane1 = wr_fire & w_strb_reg[1];

   always @(posedge mclk) begin
      if (!rstn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         aw_held_reg   <= 1'b0;
         w_held_reg    <= 1'b0;
         aw_idx_reg    <= 10'h000;
         w_data_reg    <= 32'h00000000;
         w_strb_reg    <= 4'h0;
      end else begin
         s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr[11:2];
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_idx_reg) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // calibration engine
   wire        cal_busy;
   wire        cal_done;
   wire [15:0] cal_result;
   wire        trig_write = wr_lane0 & (aw_idx_reg == `IDX_WAKE_FLAG_CLEAR);
   wire        trig_rise  = trig_write & w_data_reg[`FLAG_RC_CAL_TRIGGER] & ~cal_trigger_reg;
   wire        wake_now   = state_reg[1] & ((cfg_lower_reg[`CFG_TIMEOUT_WAKE_ARM] & (period_cnt_reg >= period_reg))
                            | (wr_lane0 & (aw_idx_reg == `IDX_WAKE_COMMAND) & w_data_reg[`CMD_LEAVE_OFF]));
   wire        timeout_hit = state_reg[1] & cfg_lower_reg[`CFG_TIMEOUT_WAKE_ARM] & (period_cnt_reg >= period_reg);
   // manual start only with the rc oscillator running
   wire        cal_start  = cold_start_reg | wake_now
                            | (trig_rise & cfg_lower_reg[`CFG_RC_OSC_ENABLE]);

   rc_fine_cal #(
      .CAL_CYCLES (CAL_CYCLES),
      .RES_WIDTH  (16)
   ) u_cal (
      .mclk    (mclk),
      .rstn    (rstn),
      .start   (cal_start),
      .rc_tick (osc_tick_reg[0] & cfg_lower_reg[`CFG_RC_OSC_ENABLE]),
      .busy    (cal_busy),
      .done    (cal_done),
      .result  (cal_result)
   );

   // selected sleep clock tick
   wire        sleep_tick = cfg_lower_reg[`CFG_SLEEP_CLOCK_SELECT] ?
                            (osc_tick_reg[0] & cfg_lower_reg[`CFG_RC_OSC_ENABLE]) :
                            (osc_tick_reg[1] & cfg_lower_reg[`CFG_CRYSTAL_OSC_ENABLE]);
   wire [15:0] count_inc   = wake_count_reg + 16'h0001;
   wire        over_thresh = count_inc > threshold_reg;
   wire        irq_clear   = trig_write & w_data_reg[`FLAG_IRQ_CLEAR];
   wire        irq_set     = wake_now & over_thresh & irq_mask_reg[`MASK_WAKE_COUNT_IRQ];
   reg  [2:0]  state_next;

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_ACTIVE: begin
            if (wr_lane0 & (aw_idx_reg == `IDX_WAKE_COMMAND) & w_data_reg[`CMD_ENTER_SLEEP])
               state_next = ST_SLEEP;
         end
         ST_SLEEP: begin
            if (wake_now)
               state_next = irq_set ? ST_OFF : ST_ACTIVE;
         end
         ST_OFF: begin
            if (wr_lane0 & (aw_idx_reg == `IDX_WAKE_COMMAND) & w_data_reg[`CMD_LEAVE_OFF])
               state_next = ST_ACTIVE;
         end
         default:
            state_next = ST_ACTIVE;
      endcase
   end

   always @(posedge mclk) begin
      if (!rstn) begin
         cfg_lower_reg            <= `RST_WAKE_CONFIG_LOWER;
         cfg_upper_reg            <= `RST_WAKE_CONFIG_UPPER;
         irq_mask_reg             <= `RST_INTERRUPT_MASK;
         threshold_reg            <= `RST_WAKE_THRESHOLD;
         period_reg               <= `RST_WAKE_PERIOD;
         wake_count_reg           <= 16'h0000;
         cal_trigger_reg          <= 1'b0;
         cold_start_reg           <= 1'b1;
         state_reg                <= ST_ACTIVE;
         period_cnt_reg           <= 16'h0000;
         general_interrupt_line_3 <= 1'b0;
      end else begin
         cold_start_reg <= 1'b0;
         state_reg      <= state_next;
         // interval counts only while asleep and armed
         if (~state_reg[1] | wake_now)
            period_cnt_reg <= 16'h0000;
         else if (sleep_tick & cfg_lower_reg[`CFG_TIMEOUT_WAKE_ARM] & ~timeout_hit)
            period_cnt_reg <= period_cnt_reg + 16'h0001;
         if (wr_lane0) begin
            case (aw_idx_reg)
               `IDX_WAKE_CONFIG_LOWER:  cfg_lower_reg <= w_data_reg[7:0];
               `IDX_WAKE_CONFIG_UPPER:  cfg_upper_reg <= w_data_reg[7:0];
               `IDX_INTERRUPT_MASK_LOW: irq_mask_reg  <= w_data_reg[7:0];
               `IDX_WAKE_THRESHOLD_A:   threshold_reg[15:8] <= w_data_reg[7:0];
               `IDX_WAKE_THRESHOLD_B:   threshold_reg[7:0]  <= w_data_reg[7:0];
               `IDX_WAKE_FLAG_CLEAR:    cal_trigger_reg <= w_data_reg[`FLAG_RC_CAL_TRIGGER];
               default: ;
            endcase
         end
         if (wr_fire & (aw_idx_reg == `IDX_WAKE_PERIOD)) begin
            if (w_strb_reg[0])
               period_reg[7:0] <= w_data_reg[7:0];
            if (wr_lane1)
               period_reg[15:8] <= w_data_reg[15:8];
         end
         // a wake-up outranks a software write to the counter
         if (wake_now)
            wake_count_reg <= over_thresh ? 16'h0000 : count_inc;
         else if (wr_fire & (aw_idx_reg == `IDX_WAKE_EVENT_COUNTER)) begin
            if (w_strb_reg[0])
               wake_count_reg[7:0] <= w_data_reg[7:0];
            if (wr_lane1)
               wake_count_reg[15:8] <= w_data_reg[15:8];
         end
         // set wins over a clear in the same cycle
         if (irq_set)
            general_interrupt_line_3 <= 1'b1;
         else if (irq_clear)
            general_interrupt_line_3 <= 1'b0;
      end
   end

   // pin-facing controls, all registered
   always @(posedge mclk) begin
      if (!rstn) begin
         rc_osc_enable       <= 1'b0;
         crystal_osc_enable  <= 1'b0;
         sleep_clock_select  <= 1'b0;
         retention_ram_power <= 1'b1;
         sleep_state         <= 1'b0;
         off_state           <= 1'b0;
      end else begin
         rc_osc_enable       <= cfg_lower_reg[`CFG_RC_OSC_ENABLE];
         crystal_osc_enable  <= cfg_lower_reg[`CFG_CRYSTAL_OSC_ENABLE];
         sleep_clock_select  <= cfg_lower_reg[`CFG_SLEEP_CLOCK_SELECT];
         retention_ram_power <= ~state_next[1] | cfg_lower_reg[`CFG_RETENTION_RAM_POWER];
         sleep_state         <= state_next[1];
         off_state           <= state_next[2];
      end
   end

   // bus read side, independent of calibration activity
   reg [31:0] rd_mux;

   always @* begin
      rd_mux = 32'h00000000;
      case (s_axi_araddr[11:2])
         `IDX_INTERRUPT_MASK_LOW:  rd_mux[7:0]  = irq_mask_reg;
         `IDX_WAKE_EVENT_COUNTER:  rd_mux[15:0] = wake_count_reg;
         `IDX_WAKE_THRESHOLD_A:    rd_mux[7:0]  = threshold_reg[15:8];
         `IDX_WAKE_THRESHOLD_B:    rd_mux[7:0]  = threshold_reg[7:0];
         `IDX_WAKE_CONFIG_UPPER:   rd_mux[7:0]  = cfg_upper_reg;
         `IDX_WAKE_CONFIG_LOWER:   rd_mux[7:0]  = cfg_lower_reg;
         `IDX_WAKE_PERIOD:         rd_mux[15:0] = period_reg;
         `IDX_WAKE_FLAG_CLEAR:     rd_mux[7:0]  = {6'h00, cal_trigger_reg, 1'b0};
         `IDX_WAKE_STATUS:         rd_mux[7:0]  = {2'h0, general_interrupt_line_3, state_reg,
                                                    cal_done, cal_busy};
         `IDX_RC_CAL_RESULT_UPPER: rd_mux[7:0]  = cal_result[15:8];
         `IDX_RC_CAL_RESULT_LOWER: rd_mux[7:0]  = cal_result[7:0];
         default:                  rd_mux       = 32'h00000000;
      endcase
   end

   always @(posedge mclk) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= mapped(s_axi_araddr[11:2]) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // wake_timer_unit

// File: sleep_osc_model.sv
/*
 * Model of the two sleep oscillators that feed the wake timer unit.
 * Assumes the unit's enable outputs gate each oscillator; half periods are shortened for simulation.
 */
`timescale 1ns/1ps

module sleep_osc_model #(
   parameter RC_HALF_NS = 40,
   parameter XO_HALF_NS = 60
) (
   // enables from the unit
   input  wire  rc_en,
   input  wire  xo_en,
   // oscillator pins
   output logic rc_clk,
   output logic xo_clk
);
   initial rc_clk = 1'b0;
   initial xo_clk = 1'b0;
   // a disabled oscillator stands still low
   always begin
      #(RC_HALF_NS);
      rc_clk = rc_en ? ~rc_clk : 1'b0;
   end
   always begin
      #(XO_HALF_NS);
      xo_clk = xo_en ? ~xo_clk : 1'b0;
   end
endmodule // sleep_osc_model

// File: wake_timer_unit_assertions.sv
/*
 * Port checker of the wake timer unit.
 * Assumes it is bound to wake_timer_unit and sees only that module's ports.
 */
`timescale 1ns/1ps
`include "wake_timer_consts.vh"

module wake_timer_unit_assertions #(
   parameter CAL_CYCLES = 300000
) (
   // clock and reset
   input wire        mclk,
   input wire        rstn,
   // register bus
   input wire [11:0] s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0]  s_axi_wstrb,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   // controls
   input wire        rc_osc_enable,
   input wire        crystal_osc_enable,
   input wire        sleep_clock_select,
   input wire        retention_ram_power,
   input wire        sleep_state,
   input wire        off_state,
   input wire        general_interrupt_line_3
);
   reg [9:0] aw_idx_reg;
   reg [7:0] wd_reg;
   reg       wok_reg;
   reg       bv_reg;
   reg [7:0] cfg_reg;
   wire      cfg_wr = s_axi_bvalid && !bv_reg && wok_reg && aw_idx_reg == `IDX_WAKE_CONFIG_LOWER;

   // mirror of the stored lower config, updated at the write's effect edge
   always @(posedge mclk) begin
      if (!rstn) begin
         aw_idx_reg <= 10'h000;
         wd_reg     <= 8'h00;
         wok_reg    <= 1'b0;
         bv_reg     <= 1'b0;
         cfg_reg    <= 8'h00;
      end else begin
         bv_reg <= s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) aw_idx_reg <= s_axi_awaddr[11:2];
         if (s_axi_wvalid && s_axi_wready) begin
            wd_reg  <= s_axi_wdata[7:0];
            wok_reg <= s_axi_wstrb[0];
         end
         if (cfg_wr) cfg_reg <= wd_reg;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_low_read;
      s_ar_taken ##0 (s_axi_araddr[11:2] < 10'h100);
   endsequence

   a_cfg_drives_pins: assert property (cfg_wr |=> rc_osc_enable == cfg_reg[6] &&
      crystal_osc_enable == cfg_reg[5] && sleep_clock_select == cfg_reg[4])
      else $error("oscillator controls differ from lower config");
   a_ram_awake: assert property (!sleep_state |-> retention_ram_power)
      else $error("retention power off outside sleep");
   a_ram_sleep: assert property (sleep_state |-> retention_ram_power == cfg_reg[3])
      else $error("retention power in sleep differs from config");
   a_irq_enters_off: assert property ($rose(general_interrupt_line_3) |-> off_state && !sleep_state)
      else $error("interrupt raised without off state");
   a_state_exclusive: assert property (!(sleep_state && off_state))
      else $error("sleep and off together");
   a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("write address ready longer than one cycle");
   a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
      else $error("read answer late");
   a_unmapped_read: assert property (s_low_read |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
endmodule // wake_timer_unit_assertions

bind wake_timer_unit wake_timer_unit_assertions #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.*);

// File: wake_timer_unit_bench.sv
/*
 * Self-checking bench of the wake timer unit over its AXI4-Lite port.
 * Assumes the shortened calibration window and the oscillator model's rates.
 */
`timescale 1ns/1ps
`include "wake_timer_consts.vh"

module wake_timer_unit_bench;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire         rc_osc_clk, crystal_osc_clk, rc_osc_enable, crystal_osc_enable, sleep_clock_select;
   wire         retention_ram_power, sleep_state, off_state, general_interrupt_line_3;
   int          error_cnt = 0, n_tests = 0;
   logic [1:0]  wr_resp, rd_resp;
   logic [31:0] d;
   typedef struct {logic [9:0] idx; logic [31:0] wd;} row_t;
   row_t        rows[6] = '{'{`IDX_INTERRUPT_MASK_LOW, 32'h01}, '{`IDX_WAKE_THRESHOLD_A, 32'h00},
                            '{`IDX_WAKE_THRESHOLD_B, 32'h02}, '{`IDX_WAKE_PERIOD, 32'h0004},
                            '{`IDX_WAKE_CONFIG_UPPER, 32'h28}, '{`IDX_WAKE_CONFIG_LOWER, 32'h70}};
   logic [7:0]  wcfg[3] = '{8'h21, 8'h51, 8'h51};
   logic [31:0] wcnt[3] = '{32'h1, 32'h2, 32'h0};

   always #2.5 mclk = ~mclk;

   wake_timer_unit #(.CAL_CYCLES(200)) u_dut (.*);
   sleep_osc_model u_osc (.rc_en(rc_osc_enable), .xo_en(crystal_osc_enable),
                          .rc_clk(rc_osc_clk), .xo_clk(crystal_osc_clk));

   task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic check_in(string nm, int lo, int hi, logic [31:0] got);
      n_tests++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         error_cnt++;
         $display("Error %s expected %0d..%0d seen %h", nm, lo, hi, got);
      end
   endtask
   task automatic wr(logic [9:0] idx, logic [31:0] wd);
      bit a = 0, w = 0;
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      while (!(a && w)) begin
         @(posedge mclk);
         if (s_axi_awready === 1'b1) begin a = 1; s_axi_awvalid <= 1'b0; end
         if (s_axi_wready === 1'b1) begin w = 1; s_axi_wvalid <= 1'b0; end
      end
      do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
      wr_resp = s_axi_bresp;
   endtask
   task automatic rd(logic [9:0] idx);
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      do @(posedge mclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      rd_resp = s_axi_rresp;
   endtask
   task automatic rchk(string nm, logic [9:0] idx, logic [31:0] exp, logic [31:0] msk);
      rd(idx);
      check(nm, exp, d & msk);
   endtask
   task automatic wait_wake();
      int n = 0;
      while (sleep_state === 1'b1 && n < 5000) begin @(posedge mclk); n++; end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      #(60000 * 5);
      error_cnt++;
      $display("Error watchdog expected finish seen timeout");
      print_verdict();
   end

   initial begin
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      check("ram_power", 1, retention_ram_power);
      rchk("cfg_upper", `IDX_WAKE_CONFIG_UPPER, 32'h28, 32'hFF);
      rchk("cfg_lower", `IDX_WAKE_CONFIG_LOWER, 32'h00, 32'hFF);
      rchk("period", `IDX_WAKE_PERIOD, 32'h20, 32'hFFFF);
      rchk("cold_cal", `IDX_WAKE_STATUS, 32'h1, 32'h1);
      $display("test reset done");
      // coarse tune 5 in bits 6..3, reserved bits written zero
      foreach (rows[i]) begin
         wr(rows[i].idx, rows[i].wd);
         check("row_resp", `RESP_OKAY, wr_resp);
         rchk("row_read", rows[i].idx, rows[i].wd, 32'hFFFF);
      end
      check("rc_en", 1, rc_osc_enable);
      check("xo_en", 1, crystal_osc_enable);
      check("clk_sel", 1, sleep_clock_select);
      wr(10'h000, 32'h5A);
      check("unmapped_wr", `RESP_SLVERR, wr_resp);
      rd(10'h000);
      check("unmapped_rd", 0, d);
      check("unmapped_rresp", `RESP_SLVERR, rd_resp);
      $display("test registers done");
      // crystal clock first, then the rc clock, third wake passes threshold 2
      for (int k = 0; k < 3; k++) begin
         wr(`IDX_WAKE_CONFIG_LOWER, {24'h0, wcfg[k]});
         wr(`IDX_WAKE_COMMAND, 32'h1);
         check("asleep", 1, sleep_state);
         check("ram_sleep_off", 0, retention_ram_power);
         wait_wake();
         check("woke", 0, sleep_state);
         rchk("wake_cnt", `IDX_WAKE_EVENT_COUNTER, wcnt[k], 32'hFFFF);
      end
      check("irq", 1, general_interrupt_line_3);
      check("off", 1, off_state);
      rchk("status_wake", `IDX_WAKE_STATUS, 32'h31, 32'h3F);
      for (int n = 0; n < 200 && d[1] !== 1'b1; n++) rd(`IDX_WAKE_STATUS);
      check("cal_done", 1, d[1]);
      rchk("cal_hi", `IDX_RC_CAL_RESULT_UPPER, 0, 32'hFF);
      rd(`IDX_RC_CAL_RESULT_LOWER);
      check_in("cal_lo", 11, 14, d);
      $display("test wake count done");
      wr(`IDX_WAKE_FLAG_CLEAR, 32'h1);
      check("irq_clear", 0, general_interrupt_line_3);
      wr(`IDX_WAKE_COMMAND, 32'h2);
      check("leave_off", 0, off_state);
      wr(`IDX_WAKE_FLAG_CLEAR, 32'h0);
      wr(`IDX_WAKE_FLAG_CLEAR, 32'h2);
      rchk("manual_cal", `IDX_WAKE_STATUS, 32'h1, 32'h1);
      $display("test manual calibration done");
      // unarmed sleep with retention kept: only the command may wake
      wr(`IDX_WAKE_CONFIG_LOWER, 32'h58);
      wr(`IDX_WAKE_COMMAND, 32'h1);
      repeat (200) @(posedge mclk);
      check("unarmed", 1, sleep_state);
      check("ram_kept", 1, retention_ram_power);
      wr(`IDX_WAKE_COMMAND, 32'h2);
      check("cmd_wake", 0, sleep_state);
      rchk("cmd_cnt", `IDX_WAKE_EVENT_COUNTER, 32'h1, 32'hFFFF);
      $display("test unarmed sleep done");
      print_verdict();
   end
endmodule // wake_timer_unit_bench
